/* File: inc/ssf_pkg.sv */
// Package with register map, field positions and timing for the flag bank.
package ssf_pkg;
  localparam logic [6:0] ADDR_THERM = 7'h42;
  localparam logic [6:0] ADDR_DEV   = 7'h43;
  localparam logic [6:0] ADDR_BUS   = 7'h44;
  localparam logic [7:0] RST_VAL    = 8'h00;
  localparam int         FRAME_BITS = 16;
  localparam int         B_THERMAL_SHUTDOWN_STAGE_TWO     = 2;
  localparam int         B_THERMAL_SHUTDOWN_STAGE_ONE     = 1;
  localparam int         B_TPW      = 0;
  localparam int         B_PRI_HI   = 7;
  localparam int         B_PRI_LO   = 6;
  localparam int         B_WDC_HI   = 3;
  localparam int         B_WDC_LO   = 2;
  localparam int         B_SPIERR   = 1;
  localparam int         B_FAIL     = 0;
  localparam int         B_TO       = 4;
  localparam int         B_SELECTIVE_WAKE_SYSTEM_ERROR   = 3;
  localparam int         B_XF_HI    = 2;
  localparam int         B_XF_LO    = 1;
  localparam int         B_UV       = 0;
  localparam logic [1:0] PRI_CLR    = 2'h0;
  localparam logic [1:0] PRI_FAIL   = 2'h1;
  localparam logic [1:0] PRI_SLEEP  = 2'h2;
  localparam logic [1:0] WDC_ZERO   = 2'h0;
  localparam logic [1:0] WDC_ONE    = 2'h1;
  localparam logic [1:0] WDC_TWO    = 2'h2;
  localparam logic [1:0] XF_NONE    = 2'h0;
  localparam logic [1:0] XF_TSD     = 2'h1;
  localparam logic [1:0] XF_TXDOM   = 2'h2;
  localparam logic [1:0] XF_BUSDOM  = 2'h3;
  localparam logic [2:0] CFG_ZERO   = 3'h0;
  localparam logic [2:0] CFG_ONE    = 3'h1;
  localparam logic [2:0] CFG_TWO    = 3'h2;
  localparam logic [2:0] CFG_THREE  = 3'h3;
  localparam logic [2:0] CFG_FOUR   = 3'h4;
  localparam int         SWK_ERR_LIMIT = 32;
  localparam int         CLK_MHZ    = 250;
  localparam int         TX_EN_NS   = 4000;
  localparam int         TX_EN_CYC  = (TX_EN_NS * CLK_MHZ + 999) / 1000;
endpackage

/* File: logic/ssf_spi_link.sv */
// SPI frame receiver and read shifter, clocked by the serial clock.
`timescale 1ns/1ps
module ssf_spi_link
  import ssf_pkg::*;
(
  input  wire logic        sclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        csn_in,
  input  wire logic        mosi_in,
  input  wire logic [7:0]  rd_data_in,
  output logic             miso_out,
  output logic [15:0]      frame_out,
  output logic             frame_tgl_out
);
  logic [15:0] shift_r;
  logic [4:0]  cnt_r;
  logic [7:0]  rd_shift_r;

  // Bit counter; select high clears it, as the serial clock stands still
  // between frames and could not clear it synchronously.
  always_ff @(posedge sclk_in or posedge csn_in)
  begin
    if (csn_in)
    begin
      cnt_r <= 5'h00;
    end
    else
    begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // Input shifter; bits arrive LSB first, address byte ahead of data.
  always_ff @(posedge sclk_in)
  begin
    if (!csn_in)
    begin
      shift_r <= {mosi_in, shift_r[15:1]};
    end
  end

  // Frame word and toggle; system reset clears them while the clock idles.
  always_ff @(posedge sclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      frame_out     <= 16'h0000;
      frame_tgl_out <= 1'b0;
    end
    else if (!csn_in && cnt_r == 5'(FRAME_BITS - 1))
    begin
      frame_out     <= {mosi_in, shift_r[15:1]};
      frame_tgl_out <= ~frame_tgl_out;
    end
  end

  // Read data shifts out LSB first on falling edges during the data byte.
  always_ff @(negedge sclk_in)
  begin
    if (cnt_r == 5'(FRAME_BITS / 2))
    begin
      rd_shift_r <= {1'b0, rd_data_in[7:1]};
      miso_out   <= rd_data_in[0];
    end
    else
    begin
      rd_shift_r <= {1'b0, rd_shift_r[7:1]};
      miso_out   <= rd_shift_r[0];
    end
  end
endmodule

/* File: logic/ssf_flag_bank.sv */
// Supervisor status flag bank: thermal, device and bus status registers.
`timescale 1ns/1ps
// Operation
// - Thermal register: stage two, stage one, prewarning.
// - Thermal flags stay until clear or reset.
// - Prior-state code records state before restart.
// - Illegal sleep requests record failure code.
// - Sleep with pending wake flags records sleep.
// - Watchdog counter counts failures, never reaches three.
// - Counter clears on good trigger or stop not caused by failure.
// - Configurations two and four freeze counter.
// - Configuration zero first failure only restarts.
// - Invalid command sets serial error flag.
// - Fail output activation sets fail flag.
// - Transceiver failure code encodes four states.
// - Bus undervoltage sets flag, disables transmitter.
// - Undervoltage detection only when mode bit set.
// - Transmit-dominant timeout ends on release.
// - Bus-dominant timeout ends on recessive bus.
// - Transmit re-enabled after input high long enough.
// - Bus timeout flag set from silence indication.
// - Timeout interrupt in stop, normal when unmasked.
// - Selective-wake error on config error or overflow.
// - Timeout clear blocked until interrupt falling edge.
// - Command: address, access bit, data byte.
// - Access bit zero reads, one clears.
module ssf_flag_bank
  import ssf_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       sclk_in,
  input  wire logic       csn_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  input  wire logic [2:0] cfg_sel_in,
  input  wire logic       thermal_shutdown_stage_two_evt_in,
  input  wire logic       thermal_shutdown_stage_one_evt_in,
  input  wire logic       tpw_evt_in,
  input  wire logic       restart_fail_in,
  input  wire logic       illegal_sleep_in,
  input  wire logic       sleep_entry_in,
  input  wire logic       sleep_wake_pending_in,
  input  wire logic       watchdog_failure_counter_evt_in,
  input  wire logic       wd_trig_ok_in,
  input  wire logic       wd_stopped_in,
  input  wire logic       wd_stop_by_fail_in,
  input  wire logic       spi_invalid_in,
  input  wire logic       xcvr_tsd_in,
  input  wire logic       txd_dom_to_in,
  input  wire logic       bus_dom_to_in,
  input  wire logic       txd_in,
  input  wire logic       bus_recessive_in,
  input  wire logic       xcvr_mode_on_in,
  input  wire logic       bus_supply_low_in,
  input  wire logic       swk_enable_in,
  input  wire logic       bus_silence_indication_in,
  input  wire logic       swk_cfg_err_in,
  input  wire logic [5:0] swk_err_cnt_in,
  input  wire logic       bus_timeout_interrupt_mask_in,
  input  wire logic       stop_or_normal_in,
  input  wire logic       int_pin_in,
  output logic            fail_safe_req_out,
  output logic            fail_output_out,
  output logic            tx_enable_out,
  output logic            bus_timeout_irq_out
);
  logic [7:0]  therm_r;
  logic [1:0]  prior_r;
  logic [1:0]  wdc_r;
  logic        wd_frozen_r;
  logic        spierr_r;
  logic        fail_r;
  logic        to_r;
  logic        selective_wake_system_error_r;
  logic [1:0]  xf_r;
  logic        uv_r;
  logic [15:0] frame_w;
  logic        tgl_w;
  logic [2:0]  tgl_sync_r;
  logic [7:0]  rd_snap_r;
  logic [7:0]  rd_data_w;
  logic [7:0]  therm_rd_w;
  logic [7:0]  dev_rd_w;
  logic [7:0]  bus_rd_w;
  logic        frame_evt_w;
  logic        clr_th_w;
  logic        clr_dev_w;
  logic        clr_bus_w;
  logic        wd_fo_w;
  logic [1:0]  int_sync_r;
  logic        int_d_r;
  logic        to_armed_r;
  logic        sil_d_r;
  logic        fault_act_w;
  logic        xf_hold_r;
  logic [15:0] txh_cnt_r;

  ssf_spi_link u_link
  (
    .sclk_in       (sclk_in),
    .rst_b_in      (rst_b_in),
    .csn_in        (csn_in),
    .mosi_in       (mosi_in),
    .rd_data_in    (rd_snap_r),
    .miso_out      (miso_out),
    .frame_out     (frame_w),
    .frame_tgl_out (tgl_w)
  );

  // Toggle crossing; the frame word is stable long before the toggle lands.
  // The read answer is held here and changes only between frames, so the
  // next frame shifts out a settled byte.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      tgl_sync_r <= 3'h0;
      rd_snap_r  <= RST_VAL;
    end
    else
    begin
      tgl_sync_r <= {tgl_sync_r[1:0], tgl_w};
      if (frame_evt_w)
      begin
        rd_snap_r <= rd_data_w;
      end
    end
  end

  // Register picked by the address byte of the frame just taken.
  assign therm_rd_w = therm_r;
  assign dev_rd_w   = {prior_r, 2'h0, wdc_r, spierr_r, fail_r};
  assign bus_rd_w   = {3'h0, to_r, selective_wake_system_error_r, xf_r, uv_r};
  always_comb
  begin
    unique case (frame_w[6:0])
      ADDR_THERM: rd_data_w = therm_rd_w;
      ADDR_DEV:   rd_data_w = dev_rd_w;
      ADDR_BUS:   rd_data_w = bus_rd_w;
      default:    rd_data_w = RST_VAL;
    endcase
  end

  // Decode of clear commands; access bit seven selects clear.
  assign frame_evt_w = (tgl_sync_r[2] != tgl_sync_r[1]);
  assign clr_th_w  = frame_evt_w && frame_w[7]
                     && frame_w[6:0] == ADDR_THERM;
  assign clr_dev_w = frame_evt_w && frame_w[7]
                     && frame_w[6:0] == ADDR_DEV;
  assign clr_bus_w = frame_evt_w && frame_w[7]
                     && frame_w[6:0] == ADDR_BUS;

  // Thermal flags are sticky; reserved bits 7:3 stay zero.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      therm_r <= RST_VAL;
    end
    else
    begin
      if (clr_th_w)
      begin
        therm_r <= RST_VAL;
      end
      if (thermal_shutdown_stage_two_evt_in)
      begin
        therm_r[B_THERMAL_SHUTDOWN_STAGE_TWO] <= 1'b1;
      end
      if (thermal_shutdown_stage_one_evt_in)
      begin
        therm_r[B_THERMAL_SHUTDOWN_STAGE_ONE] <= 1'b1;
      end
      if (tpw_evt_in)
      begin
        therm_r[B_TPW] <= 1'b1;
      end
    end
  end

  // Stage-two shutdown forces fail-safe, held until the flag is cleared.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      fail_safe_req_out <= 1'b0;
    end
    else
    begin
      fail_safe_req_out <= thermal_shutdown_stage_two_evt_in || therm_r[B_THERMAL_SHUTDOWN_STAGE_TWO];
    end
  end

  // Prior-state code; failure outranks sleep when both arrive together.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      prior_r <= PRI_CLR;
    end
    else if (restart_fail_in || illegal_sleep_in)
    begin
      prior_r <= PRI_FAIL;
    end
    else if (sleep_entry_in || sleep_wake_pending_in)
    begin
      prior_r <= PRI_SLEEP;
    end
    else if (clr_dev_w)
    begin
      prior_r <= PRI_CLR;
    end
  end

  // Fail output activation decided by configuration and failure count.
  always_comb
  begin
    wd_fo_w = 1'b0;
    if (watchdog_failure_counter_evt_in && !wd_frozen_r)
    begin
      if (cfg_sel_in == CFG_TWO)
      begin
        wd_fo_w = 1'b1;
      end
      else if (cfg_sel_in != CFG_ZERO && wdc_r == WDC_ONE)
      begin
        wd_fo_w = 1'b1;
      end
    end
  end

  // Watchdog failure counter; the host cannot clear it.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      wdc_r       <= WDC_ZERO;
      wd_frozen_r <= 1'b0;
    end
    else if (wd_trig_ok_in || (wd_stopped_in && !wd_stop_by_fail_in))
    begin
      wdc_r       <= WDC_ZERO;
      wd_frozen_r <= 1'b0;
    end
    else if (watchdog_failure_counter_evt_in && !wd_frozen_r)
    begin
      if (wdc_r != WDC_TWO)
      begin
        wdc_r <= wdc_r + WDC_ONE;
      end
      // Freeze in configurations two and four once the fail output fired, so a later miss cannot recount.
      wd_frozen_r <= wd_fo_w && ((cfg_sel_in == CFG_TWO)
                     || (cfg_sel_in == CFG_FOUR));
    end
  end

  // Serial error and fail flags; set wins over clear.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      spierr_r        <= 1'b0;
      fail_r          <= 1'b0;
      fail_output_out <= 1'b0;
    end
    else
    begin
      spierr_r <= spi_invalid_in || (spierr_r && !clr_dev_w);
      fail_r   <= wd_fo_w || thermal_shutdown_stage_two_evt_in
                  || (fail_r && !clr_dev_w);
      fail_output_out <= fail_output_out || wd_fo_w || thermal_shutdown_stage_two_evt_in;
    end
  end

  // Interrupt pin sampled through two flops, then edge-detected.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      int_sync_r <= 2'h3;
      int_d_r    <= 1'b1;
    end
    else
    begin
      int_sync_r <= {int_sync_r[0], int_pin_in};
      int_d_r    <= int_sync_r[1];
    end
  end

  // Bus timeout flag; a clear is honoured only once an interrupt fell.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      to_r       <= 1'b0;
      to_armed_r <= 1'b0;
      sil_d_r    <= 1'b0;
    end
    else
    begin
      sil_d_r <= bus_silence_indication_in;
      if (swk_enable_in && bus_silence_indication_in && !sil_d_r)
      begin
        to_r       <= 1'b1;
        to_armed_r <= 1'b0;
      end
      else
      begin
        if (int_d_r && !int_sync_r[1])
        begin
          to_armed_r <= 1'b1;
        end
        if (clr_bus_w && to_armed_r)
        begin
          to_r <= 1'b0;
        end
      end
    end
  end

  // Interrupt request while the timeout flag stands in stop or normal.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      bus_timeout_irq_out <= 1'b0;
    end
    else
    begin
      bus_timeout_irq_out <= to_r && stop_or_normal_in
                             && bus_timeout_interrupt_mask_in;
    end
  end

  // Selective-wake error and undervoltage flags.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      selective_wake_system_error_r <= 1'b0;
      uv_r     <= 1'b0;
    end
    else
    begin
      if (swk_enable_in && (swk_cfg_err_in
          || 32'(swk_err_cnt_in) > SWK_ERR_LIMIT))
      begin
        selective_wake_system_error_r <= 1'b1;
      end
      else if (clr_bus_w)
      begin
        selective_wake_system_error_r <= 1'b0;
      end
      if (xcvr_mode_on_in && bus_supply_low_in)
      begin
        uv_r <= 1'b1;
      end
      else if (clr_bus_w)
      begin
        uv_r <= 1'b0;
      end
    end
  end

  // Live fault terms; each timeout ends on its own recovery condition.
  assign fault_act_w = xcvr_tsd_in
      || (txd_dom_to_in && !txd_in && xcvr_mode_on_in)
      || (bus_dom_to_in && !bus_recessive_in && xcvr_mode_on_in)
      || (xcvr_mode_on_in && bus_supply_low_in);

  // Transceiver failure code; the newest code overrides, the higher one when several arrive together.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      xf_r <= XF_NONE;
    end
    else if (bus_dom_to_in)
    begin
      xf_r <= XF_BUSDOM;
    end
    else if (txd_dom_to_in)
    begin
      xf_r <= XF_TXDOM;
    end
    else if (xcvr_tsd_in)
    begin
      xf_r <= XF_TSD;
    end
    else if (clr_bus_w)
    begin
      xf_r <= XF_NONE;
    end
  end

  // Transmitter re-enable needs the transmit input high for a while.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      xf_hold_r     <= 1'b0;
      txh_cnt_r     <= 16'h0000;
      tx_enable_out <= 1'b1;
    end
    else if (fault_act_w)
    begin
      xf_hold_r     <= 1'b1;
      txh_cnt_r     <= 16'h0000;
      tx_enable_out <= 1'b0;
    end
    else if (xf_hold_r)
    begin
      if (!txd_in)
      begin
        txh_cnt_r <= 16'h0000;
      end
      else if (txh_cnt_r == 16'(TX_EN_CYC - 1))
      begin
        xf_hold_r     <= 1'b0;
        tx_enable_out <= 1'b1;
      end
      else
      begin
        txh_cnt_r <= txh_cnt_r + 16'h0001;
      end
    end
  end
endmodule

/* File: tb/ssf_spi_host.sv */
// Host controller model that drives 16-bit frames on the serial port.
`timescale 1ns/1ps
module ssf_spi_host
(
  output logic      sclk_out,
  output logic      csn_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  // The clock stays low and select stays high between frames.
  initial
  begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Sends one frame LSB first, address byte ahead of the data byte, and
  // collects the data byte from the device.
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    #3.1 csn_out = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      mosi_out = tx[i];
      #6 sclk_out = 1'b1;
      if (i >= 8)
        rx = {miso_in, rx[7:1]};
      #6 sclk_out = 1'b0;
    end
    #6 csn_out = 1'b1;
    // A released line must not keep looking valid.
    mosi_out = ~mosi_out;
    #24;
  endtask
endmodule

/* File: tb/ssf_flag_bank_checker.sv */
// Assertion checker for the status flag bank.
`timescale 1ns/1ps
module ssf_flag_bank_checker
  import ssf_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic [2:0] cfg_sel_in,
  input wire logic       thermal_shutdown_stage_two_evt_in,
  input wire logic       watchdog_failure_counter_evt_in,
  input wire logic       txd_in,
  input wire logic       xcvr_mode_on_in,
  input wire logic       bus_supply_low_in,
  input wire logic       swk_enable_in,
  input wire logic       bus_silence_indication_in,
  input wire logic       bus_timeout_interrupt_mask_in,
  input wire logic       stop_or_normal_in,
  input wire logic       fail_safe_req_out,
  input wire logic       fail_output_out,
  input wire logic       tx_enable_out,
  input wire logic       bus_timeout_irq_out
);
  int hi_cnt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Counts how long the transmit input has stayed high, saturating.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in || !txd_in)
      hi_cnt <= 0;
    else if (hi_cnt < TX_EN_CYC)
      hi_cnt <= hi_cnt + 1;
  end
  chk_uv_tx_off: assert property (xcvr_mode_on_in && bus_supply_low_in
    |-> ##[1:3] !tx_enable_out) else $error("tx stays on in undervoltage");
  chk_tx_wait: assert property ($rose(tx_enable_out)
    |-> hi_cnt >= TX_EN_CYC - 4) else $error("tx back too early");
  chk_tx_uv_gone: assert property ($rose(tx_enable_out)
    |-> !($past(xcvr_mode_on_in) && $past(bus_supply_low_in)))
    else $error("tx back during undervoltage");
  chk_irq_cause: assert property ($rose(bus_timeout_irq_out)
    |-> $past(bus_timeout_interrupt_mask_in) && $past(stop_or_normal_in))
    else $error("timeout irq without mask or mode");
  chk_irq_rise: assert property (swk_enable_in &&
    bus_silence_indication_in && bus_timeout_interrupt_mask_in &&
    stop_or_normal_in |-> ##[1:4] bus_timeout_irq_out)
    else $error("timeout irq missing");
  chk_fail_safe: assert property (thermal_shutdown_stage_two_evt_in
    |-> ##[1:3] fail_safe_req_out) else $error("no fail-safe request");
  chk_fail_cfg2: assert property (cfg_sel_in == CFG_TWO &&
    watchdog_failure_counter_evt_in |-> ##[1:3] fail_output_out) else $error("no fail out");
  chk_fail_sticky: assert property (fail_output_out
    |=> fail_output_out) else $error("fail output dropped");
  cover property ($fell(tx_enable_out));
  cover property ($rose(bus_timeout_irq_out));
  cover property ($rose(fail_safe_req_out));
endmodule
bind ssf_flag_bank ssf_flag_bank_checker u_ssf_flag_bank_checker (.clk_in,
  .rst_b_in, .cfg_sel_in, .thermal_shutdown_stage_two_evt_in, .watchdog_failure_counter_evt_in, .txd_in,
  .xcvr_mode_on_in, .bus_supply_low_in, .swk_enable_in,
  .bus_silence_indication_in, .bus_timeout_interrupt_mask_in,
  .stop_or_normal_in, .fail_safe_req_out, .fail_output_out, .tx_enable_out,
  .bus_timeout_irq_out);

/* File: tb/tb_ssf_flag_bank.sv */
// Self-checking bench for the supervisor status flag bank.
`timescale 1ns/1ps
module tb_ssf_flag_bank;
  import ssf_pkg::*;
  logic       clk_in, rst_b_in, sclk_in, csn_in, mosi_in, miso_out;
  logic [2:0] cfg_sel_in;
  logic [5:0] swk_err_cnt_in;
  logic       thermal_shutdown_stage_two_evt_in, thermal_shutdown_stage_one_evt_in, tpw_evt_in, restart_fail_in;
  logic       illegal_sleep_in, sleep_entry_in, sleep_wake_pending_in;
  logic       watchdog_failure_counter_evt_in, wd_trig_ok_in, wd_stopped_in;
  logic       wd_stop_by_fail_in, spi_invalid_in, xcvr_tsd_in;
  logic       txd_dom_to_in, bus_dom_to_in, txd_in, bus_recessive_in;
  logic       xcvr_mode_on_in, bus_supply_low_in, swk_enable_in;
  logic       bus_silence_indication_in, swk_cfg_err_in, int_pin_in;
  logic       bus_timeout_interrupt_mask_in, stop_or_normal_in;
  logic       fail_safe_req_out, fail_output_out, tx_enable_out;
  logic       bus_timeout_irq_out;
  logic [7:0] d;
  int         bad_count = 0;
  int         total_checks = 0;
  // Device and the host model on its serial port.
  ssf_flag_bank u_ssf_flag_bank (.clk_in, .rst_b_in, .sclk_in, .csn_in,
    .mosi_in, .miso_out, .cfg_sel_in, .thermal_shutdown_stage_two_evt_in, .thermal_shutdown_stage_one_evt_in,
    .tpw_evt_in, .restart_fail_in, .illegal_sleep_in, .sleep_entry_in,
    .sleep_wake_pending_in, .watchdog_failure_counter_evt_in, .wd_trig_ok_in,
    .wd_stopped_in, .wd_stop_by_fail_in, .spi_invalid_in, .xcvr_tsd_in,
    .txd_dom_to_in, .bus_dom_to_in, .txd_in, .bus_recessive_in,
    .xcvr_mode_on_in, .bus_supply_low_in, .swk_enable_in,
    .bus_silence_indication_in, .swk_cfg_err_in, .swk_err_cnt_in,
    .bus_timeout_interrupt_mask_in, .stop_or_normal_in, .int_pin_in,
    .fail_safe_req_out, .fail_output_out, .tx_enable_out,
    .bus_timeout_irq_out);
  ssf_spi_host u_ssf_spi_host (.sclk_out(sclk_in), .csn_out(csn_in),
    .mosi_out(mosi_in), .miso_in(miso_out));
  // System clock.
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A read is answered in the following frame, so the command goes twice.
  task automatic rd(input logic [6:0] a);
    u_ssf_spi_host.xfer({8'h00, 1'b0, a}, d);
    u_ssf_spi_host.xfer({8'h00, 1'b0, a}, d);
    step(10);
  endtask
  task automatic clr(input logic [6:0] a);
    logic [7:0] x;
    u_ssf_spi_host.xfer({8'h00, 1'b1, a}, x);
    step(10);
  endtask
  task automatic do_reset;
    rst_b_in = 1'b0;
    step(8);
    rst_b_in = 1'b1;
    step(4);
  endtask
  task automatic t_thermal;
    do_reset();
    for (int i = 0; i < 4; i++)
    begin
      rd(ADDR_THERM + 7'(i));
      check(d, RST_VAL);
    end
    {thermal_shutdown_stage_two_evt_in, thermal_shutdown_stage_one_evt_in, tpw_evt_in} = 3'h7;
    step(1);
    {thermal_shutdown_stage_two_evt_in, thermal_shutdown_stage_one_evt_in, tpw_evt_in} = 3'h0;
    step(20);
    rd(ADDR_THERM);
    check(d, 8'h07);
    check({7'h00, fail_safe_req_out}, 8'h01);
    clr(ADDR_THERM);
    rd(ADDR_THERM);
    check(d, 8'h00);
  endtask
  task automatic t_device;
    do_reset();
    cfg_sel_in = CFG_TWO;
    {restart_fail_in, watchdog_failure_counter_evt_in, spi_invalid_in} = 3'h7;
    step(1);
    {restart_fail_in, watchdog_failure_counter_evt_in, spi_invalid_in} = 3'h0;
    step(5);
    watchdog_failure_counter_evt_in = 1'b1;
    step(1);
    watchdog_failure_counter_evt_in = 1'b0;
    rd(ADDR_DEV);
    check(d, 8'h47);
    clr(ADDR_DEV);
    rd(ADDR_DEV);
    check(d, 8'h04);
    wd_trig_ok_in = 1'b1;
    step(1);
    wd_trig_ok_in = 1'b0;
    rd(ADDR_DEV);
    check(d, 8'h00);
    watchdog_failure_counter_evt_in = 1'b1;
    step(1);
    watchdog_failure_counter_evt_in = 1'b0;
    {wd_stopped_in, wd_stop_by_fail_in} = 2'h3;
    step(2);
    rd(ADDR_DEV);
    check(d, 8'h05);
    wd_stop_by_fail_in = 1'b0;
    step(2);
    wd_stopped_in = 1'b0;
    rd(ADDR_DEV);
    check(d, 8'h01);
    clr(ADDR_DEV);
    {sleep_entry_in, sleep_wake_pending_in} = 2'h3;
    step(1);
    {sleep_entry_in, sleep_wake_pending_in} = 2'h0;
    rd(ADDR_DEV);
    check(d, 8'h80);
    illegal_sleep_in = 1'b1;
    step(1);
    illegal_sleep_in = 1'b0;
    rd(ADDR_DEV);
    check(d, 8'h40);
  endtask
  // Failure count and fail flag for one configuration.
  task automatic t_wd(input logic [2:0] c, input int n,
                      input logic [7:0] m, input logic [7:0] e);
    do_reset();
    cfg_sel_in = c;
    repeat (n)
    begin
      watchdog_failure_counter_evt_in = 1'b1;
      step(1);
      watchdog_failure_counter_evt_in = 1'b0;
      step(5);
    end
    rd(ADDR_DEV);
    check(d & m, e);
    check({7'h00, fail_output_out}, {7'h00, e[0]});
  endtask
  task automatic t_bus;
    do_reset();
    bus_supply_low_in = 1'b1;
    step(20);
    rd(ADDR_BUS);
    check(d, 8'h00);
    {xcvr_mode_on_in, swk_enable_in, bus_silence_indication_in} = 3'h7;
    {bus_timeout_interrupt_mask_in, stop_or_normal_in} = 2'h3;
    {swk_err_cnt_in, txd_dom_to_in} = {6'h21, 1'b1};
    step(5);
    check({6'h00, tx_enable_out, bus_timeout_irq_out}, 8'h01);
    {bus_silence_indication_in, txd_dom_to_in, txd_in} = 3'h0;
    {swk_err_cnt_in, bus_supply_low_in} = 7'h00;
    step(20);
    rd(ADDR_BUS);
    check(d, 8'h1D);
    clr(ADDR_BUS);
    rd(ADDR_BUS);
    check(d, 8'h10);
    int_pin_in = 1'b0;
    step(5);
    int_pin_in = 1'b1;
    clr(ADDR_BUS);
    rd(ADDR_BUS);
    check(d, 8'h00);
    // The host holds the transmit input high for the enable time.
    txd_in = 1'b1;
    step(TX_EN_CYC - 20);
    check({7'h00, tx_enable_out}, 8'h00);
    step(40);
    check({7'h00, tx_enable_out}, 8'h01);
    // Thermal fault, then a bus-dominant timeout that ends on a recessive bus.
    xcvr_tsd_in = 1'b1;
    step(1);
    xcvr_tsd_in = 1'b0;
    bus_dom_to_in = 1'b1;
    step(5);
    bus_recessive_in = 1'b1;
    step(5);
    bus_dom_to_in = 1'b0;
    rd(ADDR_BUS);
    check(d, 8'h06);
    check({7'h00, tx_enable_out}, 8'h00);
    step(TX_EN_CYC);
    check({7'h00, tx_enable_out}, 8'h01);
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hang short well after all scenarios should have ended.
  initial
  begin
    #300000;
    bad_count++;
    test_done();
  end
  // Main sequence.
  initial
  begin
    {cfg_sel_in, swk_err_cnt_in, thermal_shutdown_stage_two_evt_in, thermal_shutdown_stage_one_evt_in} = '0;
    {tpw_evt_in, restart_fail_in, illegal_sleep_in, sleep_entry_in} = '0;
    {sleep_wake_pending_in, watchdog_failure_counter_evt_in, wd_trig_ok_in} = '0;
    {wd_stopped_in, wd_stop_by_fail_in, spi_invalid_in, xcvr_tsd_in} = '0;
    {txd_dom_to_in, bus_dom_to_in, bus_recessive_in} = '0;
    {xcvr_mode_on_in, bus_supply_low_in, swk_enable_in} = '0;
    {bus_silence_indication_in, swk_cfg_err_in, stop_or_normal_in} = '0;
    bus_timeout_interrupt_mask_in = 1'b0;
    {txd_in, int_pin_in, rst_b_in} = 3'h6;
    step(1);
    t_thermal();
    t_device();
    t_wd(CFG_ZERO, 1, 8'h0D, 8'h04);
    t_wd(CFG_ONE, 2, 8'h0D, 8'h09);
    t_wd(CFG_THREE, 2, 8'h0D, 8'h09);
    t_wd(CFG_FOUR, 3, 8'h0D, 8'h09);
    t_bus();
    test_done();
  end
endmodule
